// ===== design/dmos_pkg.sv
/*
 * Constants and types shared by the monitor output scaler.
 * Assumes a single 125 MHz clock and an AXI4-Lite register bus.
 */
`default_nettype none
package dmos_pkg;
    // ************************************************
    // Timing
    // ************************************************
    localparam int CLOCK_PERIOD_NS = 8;
    localparam int UPDATE_PERIOD_NS = 1000;
    localparam int UPDATE_CYCLES = UPDATE_PERIOD_NS / CLOCK_PERIOD_NS;
    localparam logic [6:0] UPDATE_COUNT_MAX = 7'(UPDATE_CYCLES - 1);

    // ************************************************
    // Bus and register map
    // ************************************************
    localparam int ADDR_W = 12;
    localparam logic [9:0] CTRL_INDEX = 10'h0F6;
    localparam logic [9:0] STATUS_INDEX = 10'h0F7;
    localparam logic [11:0] CTRL_BYTE_ADDR = {CTRL_INDEX, 2'b00};
    localparam logic [11:0] STATUS_BYTE_ADDR = {STATUS_INDEX, 2'b00};
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ************************************************
    // Control register fields
    // ************************************************
    localparam int VAR_ADDR_LSB = 0;
    localparam int VAR_ADDR_W = 14;
    localparam int RANGE_BIT = 14;
    localparam int LIN_LSB = 15;
    localparam int LIN_W = 4;
    localparam int POW2_LSB = 19;
    localparam int POW2_W = 4;
    localparam logic [13:0] VAR_ADDR_RESET = 14'h0000;
    localparam logic RANGE_RESET = 1'b0;
    localparam logic [3:0] LIN_RESET = 4'h8;
    localparam logic [3:0] POW2_RESET = 4'h0;
    localparam logic [31:0] CTRL_WMASK = 32'h007FFFFF;

    // ************************************************
    // Scaling and output coding
    // ************************************************
    localparam int LIN_DIV_SHIFT = 3;
    localparam int POW2_SHIFT_W = 5;
    localparam int PU_FRAC_BITS = 15;
    localparam logic signed [63:0] PU_ONE = 64'sh0000000000008000;
    localparam int DAC_W = 12;
    localparam logic signed [63:0] DAC_FULL = 64'sh0000000000000FFF;

    // ************************************************
    // Bus state machines
    // ************************************************
    typedef enum logic [1:0] {
        WR_IDLE = 2'b01,
        WR_RESP = 2'b10
    } dmos_wr_state_t;
    typedef enum logic [1:0] {
        RD_IDLE = 2'b01,
        RD_DATA = 2'b10
    } dmos_rd_state_t;
endpackage
`default_nettype wire

// ===== design/dmos_rate_divider.sv
/*
 * Update-rate divider: one-cycle enable pulse per output update.
 * Assumes the system clock; no other domain is involved.
 */
`timescale 1ns/1ps
`default_nettype none
module dmos_rate_divider (
    input wire logic clock,
    input wire logic srst,
    output logic tick
);
    import dmos_pkg::*;

    logic [6:0] count_ff;
    logic [6:0] nxt_count;
    logic tick_ff;
    logic nxt_tick;

    // ************************************************
    // Counter
    // ************************************************
    // Wraps at the update period and flags the wrap
    always_comb begin
        nxt_tick = (count_ff == UPDATE_COUNT_MAX);
        nxt_count = nxt_tick ? 7'h00 : count_ff + 7'h01;
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            count_ff <= 7'h00;
            tick_ff <= 1'b0;
        end else begin
            count_ff <= nxt_count;
            tick_ff <= nxt_tick;
        end
    end

    assign tick = tick_ff;
endmodule
`default_nettype wire

// ===== design/dmos_scaler.sv
/*
 * Scales the monitored variable and maps it onto the DAC code.
 * Assumes the variable is signed per-unit with 15 fraction bits
 * and arrives from logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
module dmos_scaler (
    input wire logic clock,
    input wire logic srst,
    input wire logic sample_en,
    input wire logic [31:0] variable_value,
    input wire logic [3:0] lin_scale,
    input wire logic [3:0] pow2_select,
    input wire logic single_sided,
    output logic [11:0] code,
    output logic code_strobe,
    output logic clipped
);
    import dmos_pkg::*;

    logic [11:0] code_ff;
    logic [11:0] nxt_code;
    logic strobe_ff;
    logic clip_ff;
    logic nxt_clip;

    // ************************************************
    // Scale, clip and code
    // ************************************************
    // 64-bit path so a shift of 15 on a 32-bit value cannot wrap
    always_comb begin
        logic signed [63:0] v;
        logic signed [63:0] scaled;
        logic signed [63:0] lo;
        logic signed [63:0] sat;
        logic signed [63:0] full;
        logic [POW2_SHIFT_W-1:0] shift;
        v = {{32{variable_value[31]}}, variable_value};
        scaled = 64'sh0;
        lo = 64'sh0;
        sat = 64'sh0;
        full = 64'sh0;
        shift = {1'b0, pow2_select}; // Width caps it at 15
        if (lin_scale != 4'h0) begin
            scaled = (v * $signed({60'h0, lin_scale})) >>> LIN_DIV_SHIFT;
        end else begin
            scaled = v <<< shift; // Zero factor selects power of two
        end
        // Single-sided clips at 0 pu, otherwise at -1 pu
        lo = single_sided ? 64'sh0 : -PU_ONE;
        nxt_clip = (scaled > PU_ONE) || (scaled < lo);
        if (scaled > PU_ONE) begin
            sat = PU_ONE;
        end else if (scaled < lo) begin
            sat = lo;
        end else begin
            sat = scaled;
        end
        if (single_sided) begin
            full = (sat * DAC_FULL) >>> PU_FRAC_BITS; // 0 pu to 0V, 1 pu to full
        end else begin
            full = ((sat + PU_ONE) * DAC_FULL) >>> (PU_FRAC_BITS + 1); // Mid-scale offset
        end
        nxt_code = full[DAC_W-1:0];
    end

    // Output only moves on the update pulse
    always_ff @(posedge clock) begin
        if (srst) begin
            code_ff <= 12'h000;
            strobe_ff <= 1'b0;
            clip_ff <= 1'b0;
        end else begin
            strobe_ff <= sample_en;
            if (sample_en) begin
                code_ff <= nxt_code;
                clip_ff <= nxt_clip;
            end
        end
    end

    assign code = code_ff;
    assign code_strobe = strobe_ff;
    assign clipped = clip_ff;
endmodule
`default_nettype wire

// ===== design/dmos_top.sv
/*
 * Second DAC monitor channel: control register on AXI4-Lite,
 * variable selection, scaling and DAC code generation.
 * Assumes the variable store answers the address combinationally
 * or with a fixed latency on the same clock, and a DAC that takes
 * a 12-bit code where 0 is 0V and all ones is 3V.
 */
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Nonzero 4-bit linear factor, bits 18:15, reset 8, scales by factor/8.
// - Bits 22:19 multiply by two to that power only when linear factor zero.
// - Zero linear factor means enumerated power-of-two scaling, at most 15.
// - Range bit 14 set: 0 pu gives 0V, 1 pu gives 3V.
// - Range bit clear (reset): -1 pu gives 0V, +1 pu 3V, 1.5V centre.
// - Readable writable 14-bit address, bits 13:0, reset zero, picks the variable.
module dmos_top (
    input wire logic clock,
    input wire logic srst,
    input wire logic [dmos_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [dmos_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [13:0] monitored_variable_address,
    input wire logic [31:0] monitored_variable_value,
    output logic [11:0] monitor_output_two,
    output logic monitor_output_two_strobe,
    output logic monitor_output_two_clipped
);
    import dmos_pkg::*;

    // ************************************************
    // Declarations
    // ************************************************
    dmos_wr_state_t wr_state_ff;
    dmos_wr_state_t nxt_wr_state;
    logic aw_held_ff;
    logic nxt_aw_held;
    logic w_held_ff;
    logic nxt_w_held;
    logic [ADDR_W-1:0] awaddr_ff;
    logic [ADDR_W-1:0] nxt_awaddr;
    logic [31:0] wdata_ff;
    logic [31:0] nxt_wdata;
    logic [3:0] wstrb_ff;
    logic [3:0] nxt_wstrb;
    logic [1:0] bresp_ff;
    logic [1:0] nxt_bresp;

    dmos_rd_state_t rd_state_ff;
    dmos_rd_state_t nxt_rd_state;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic [1:0] rresp_ff;
    logic [1:0] nxt_rresp;

    logic [31:0] ctrl_ff;
    logic [31:0] nxt_ctrl;
    logic [31:0] merged_word;
    logic [31:0] ctrl_read_word;
    logic [31:0] status_word;

    logic aw_fire;
    logic w_fire;
    logic ar_fire;
    logic aw_have;
    logic w_have;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_commit;
    logic ctrl_write;

    logic update_tick;
    logic [11:0] scaled_code;
    logic scaled_strobe;
    logic scaled_clip;

    // ************************************************
    // Write channel handshakes
    // ************************************************
    // Address and data are each taken once, in either order
    assign s_axi_awready = (wr_state_ff == WR_IDLE) && !aw_held_ff;
    assign s_axi_wready = (wr_state_ff == WR_IDLE) && !w_held_ff;
    assign aw_fire = s_axi_awvalid && s_axi_awready;
    assign w_fire = s_axi_wvalid && s_axi_wready;
    assign aw_have = aw_held_ff || aw_fire;
    assign w_have = w_held_ff || w_fire;
    assign wr_addr = aw_held_ff ? awaddr_ff : s_axi_awaddr;
    assign wr_data = w_held_ff ? wdata_ff : s_axi_wdata;
    assign wr_strb = w_held_ff ? wstrb_ff : s_axi_wstrb;
    assign wr_commit = (wr_state_ff == WR_IDLE) && aw_have && w_have;
    assign ctrl_write = wr_commit && (wr_addr[ADDR_W-1:2] == CTRL_INDEX);

    // ************************************************
    // Write state machine
    // ************************************************
    // Response waits until both halves are in; one write at a time
    always_comb begin
        nxt_wr_state = wr_state_ff;
        nxt_aw_held = aw_held_ff;
        nxt_w_held = w_held_ff;
        nxt_awaddr = awaddr_ff;
        nxt_wdata = wdata_ff;
        nxt_wstrb = wstrb_ff;
        nxt_bresp = bresp_ff;
        unique case (wr_state_ff)
            WR_IDLE: begin
                if (aw_fire) begin
                    nxt_aw_held = 1'b1;
                    nxt_awaddr = s_axi_awaddr;
                end
                if (w_fire) begin
                    nxt_w_held = 1'b1;
                    nxt_wdata = s_axi_wdata;
                    nxt_wstrb = s_axi_wstrb;
                end
                if (wr_commit) begin
                    nxt_wr_state = WR_RESP;
                    // Status is read-only, so a write there is an error
                    nxt_bresp = ctrl_write ? RESP_OKAY : RESP_SLVERR;
                end
            end
            WR_RESP: begin
                if (s_axi_bready) begin
                    nxt_wr_state = WR_IDLE;
                    nxt_aw_held = 1'b0;
                    nxt_w_held = 1'b0;
                end
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            wr_state_ff <= WR_IDLE;
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            awaddr_ff <= '0;
            wdata_ff <= 32'h00000000;
            wstrb_ff <= 4'h0;
            bresp_ff <= RESP_OKAY;
        end else begin
            wr_state_ff <= nxt_wr_state;
            aw_held_ff <= nxt_aw_held;
            w_held_ff <= nxt_w_held;
            awaddr_ff <= nxt_awaddr;
            wdata_ff <= nxt_wdata;
            wstrb_ff <= nxt_wstrb;
            bresp_ff <= nxt_bresp;
        end
    end

    assign s_axi_bvalid = (wr_state_ff == WR_RESP);
    assign s_axi_bresp = bresp_ff;

    // ************************************************
    // Control register
    // ************************************************
    // Byte-lane merge, one lane per strobe bit
    for (genvar lane = 0; lane < 4; lane++) begin : g_lane
        assign merged_word[lane*8 +: 8] = wr_strb[lane] ? wr_data[lane*8 +: 8] : ctrl_ff[lane*8 +: 8];
    end

    // Reserved bits never leave zero, whatever is written
    always_comb begin
        nxt_ctrl = ctrl_ff;
        if (ctrl_write) begin
            nxt_ctrl = merged_word & CTRL_WMASK;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            ctrl_ff <= 32'h00000000;
            ctrl_ff[VAR_ADDR_LSB +: VAR_ADDR_W] <= VAR_ADDR_RESET;
            ctrl_ff[RANGE_BIT] <= RANGE_RESET; // Bipolar after reset
            ctrl_ff[LIN_LSB +: LIN_W] <= LIN_RESET; // Unity factor after reset
            ctrl_ff[POW2_LSB +: POW2_W] <= POW2_RESET;
        end else begin
            ctrl_ff <= nxt_ctrl;
        end
    end

    // ************************************************
    // Read-back words
    // ************************************************
    // Scaling and range fields are write-only and read as zero;
    // only the variable address comes back
    always_comb begin
        ctrl_read_word = 32'h00000000;
        ctrl_read_word[VAR_ADDR_LSB +: VAR_ADDR_W] = ctrl_ff[VAR_ADDR_LSB +: VAR_ADDR_W];
        status_word = 32'h00000000;
        status_word[DAC_W-1:0] = scaled_code;
        status_word[DAC_W] = scaled_clip;
    end

    // ************************************************
    // Read state machine
    // ************************************************
    // Data is captured at address time so it holds while rvalid waits
    assign s_axi_arready = (rd_state_ff == RD_IDLE);
    assign ar_fire = s_axi_arvalid && s_axi_arready;

    always_comb begin
        nxt_rd_state = rd_state_ff;
        nxt_rdata = rdata_ff;
        nxt_rresp = rresp_ff;
        unique case (rd_state_ff)
            RD_IDLE: begin
                if (ar_fire) begin
                    nxt_rd_state = RD_DATA;
                    nxt_rresp = RESP_OKAY;
                    if (s_axi_araddr[ADDR_W-1:2] == CTRL_INDEX) begin
                        nxt_rdata = ctrl_read_word;
                    end else if (s_axi_araddr[ADDR_W-1:2] == STATUS_INDEX) begin
                        nxt_rdata = status_word;
                    end else begin
                        nxt_rdata = 32'h00000000;
                        nxt_rresp = RESP_SLVERR;
                    end
                end
            end
            RD_DATA: begin
                if (s_axi_rready) begin
                    nxt_rd_state = RD_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            rd_state_ff <= RD_IDLE;
            rdata_ff <= 32'h00000000;
            rresp_ff <= RESP_OKAY;
        end else begin
            rd_state_ff <= nxt_rd_state;
            rdata_ff <= nxt_rdata;
            rresp_ff <= nxt_rresp;
        end
    end

    assign s_axi_rvalid = (rd_state_ff == RD_DATA);
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;

    // ************************************************
    // Variable selection and scaling
    // ************************************************
    // The address goes straight from the register; any offset may be
    // driven out, keeping to listed ones is up to software
    assign monitored_variable_address = ctrl_ff[VAR_ADDR_LSB +: VAR_ADDR_W];

    // Fixed update rate keeps the DAC from seeing mid-write settings
    dmos_rate_divider u_rate (
        .clock(clock),
        .srst(srst),
        .tick(update_tick)
    );

    dmos_scaler u_scaler (
        .clock(clock),
        .srst(srst),
        .sample_en(update_tick),
        .variable_value(monitored_variable_value),
        .lin_scale(ctrl_ff[LIN_LSB +: LIN_W]),
        .pow2_select(ctrl_ff[POW2_LSB +: POW2_W]),
        .single_sided(ctrl_ff[RANGE_BIT]),
        .code(scaled_code),
        .code_strobe(scaled_strobe),
        .clipped(scaled_clip)
    );

    assign monitor_output_two = scaled_code;
    assign monitor_output_two_strobe = scaled_strobe;
    assign monitor_output_two_clipped = scaled_clip;
endmodule
`default_nettype wire

// ===== tb/dmos_checker_sva.sv
/*
 * Port checker for the monitor output scaler: bus handshakes, register
 * read-back and output update timing. Assumes one clock and srst.
 */
`timescale 1ns/1ps
`default_nettype none
module dmos_checker (
    input wire logic clock,
    input wire logic srst,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [13:0] monitored_variable_address,
    input wire logic [11:0] monitor_output_two,
    input wire logic monitor_output_two_strobe,
    input wire logic monitor_output_two_clipped
);
    import dmos_pkg::*;
    // ****************************************
    // Properties, all on the one system clock
    // ****************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    // Bus answers come one cycle after the request is taken
    a_write_answer: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
        else $error("write response late");
    a_bresp_holds: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_read_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read data late");
    a_rdata_holds: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    // Upper bits never read back, whichever register is addressed
    a_reserved_zero: assert property (
        s_axi_rvalid |-> s_axi_rdata[31:14] == 18'h0)
        else $error("reserved bits read nonzero");
    // Skipping the first edge after reset avoids comparing against pre-reset values
    a_addr_on_write: assert property (
        !$past(srst) && $changed(monitored_variable_address) |-> $rose(s_axi_bvalid))
        else $error("address moved without a write");
    a_update_period: assert property (
        monitor_output_two_strobe |-> ##125 monitor_output_two_strobe)
        else $error("update period wrong");
    a_code_held: assert property (
        !$past(srst) && !monitor_output_two_strobe |-> $stable(monitor_output_two))
        else $error("code moved between updates");
    a_clip_full: assert property (
        monitor_output_two_strobe && monitor_output_two_clipped
        |-> monitor_output_two == 12'hFFF || monitor_output_two == 12'h000)
        else $error("clipped code not at a rail");

    c_clipped: cover property (monitor_output_two_strobe && monitor_output_two_clipped);
    c_refused: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
    c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule

bind dmos_top dmos_checker chk (
    .clock(clock), .srst(srst), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .monitored_variable_address(monitored_variable_address),
    .monitor_output_two(monitor_output_two), .monitor_output_two_strobe(monitor_output_two_strobe),
    .monitor_output_two_clipped(monitor_output_two_clipped)
);
`default_nettype wire

// ===== tb/tb_dac_monitor_output_scaler.sv
/*
 * Self-checking bench for the monitor output scaler.
 * Assumes the bench plays both bus master and variable store.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_dac_monitor_output_scaler;
    import dmos_pkg::*;
    typedef struct packed {
        logic [31:0] value;
        logic [31:0] ctrl;
        logic [11:0] code;
        logic clip;
    } dmos_row_t;
    logic clock = 1'h0;
    logic srst = 1'h1;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [31:0] s_axi_wdata = 32'h0, monitored_variable_value = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [31:0] s_axi_rdata, data;
    logic [13:0] monitored_variable_address;
    logic [11:0] monitor_output_two;
    logic monitor_output_two_strobe, monitor_output_two_clipped;
    int failures = 0;
    int samples_checked = 0;
    // Variable, control word, expected code and clip flag
    dmos_row_t rows [11] = '{
        '{32'h00004000, 32'h00044123, 12'h7FF, 1'h0}, '{32'h00004000, 32'h007C0234, 12'hBFF, 1'h0},
        '{32'hFFFF8000, 32'h00040000, 12'h000, 1'h0}, '{32'h00008000, 32'h0007C000, 12'hFFF, 1'h1},
        '{32'h00001000, 32'h0000C000, 12'h03F, 1'h0}, '{32'h00001000, 32'h00184000, 12'hFFF, 1'h0},
        '{32'h00000100, 32'h00780000, 12'hFFF, 1'h1}, '{32'hFFFFFFFF, 32'h0001C000, 12'h000, 1'h1},
        '{32'h00002000, 32'h00003FFF, 12'h9FF, 1'h0}, '{32'hFFFFC000, 32'h00061555, 12'h1FF, 1'h0},
        '{32'h00008000, 32'hFF84720A, 12'hFFF, 1'h0}};

    always #(CLOCK_PERIOD_NS / 2) clock = ~clock;

    dmos_top uut (
        .clock(clock), .srst(srst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .monitored_variable_address(monitored_variable_address),
        .monitored_variable_value(monitored_variable_value),
        .monitor_output_two(monitor_output_two), .monitor_output_two_strobe(monitor_output_two_strobe),
        .monitor_output_two_clipped(monitor_output_two_clipped)
    );

    // ****************************************
    // Bus and check tasks
    // ****************************************
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // Address and data offered together; each released on its own ready
    task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                             output logic [1:0] r);
        logic done;
        done = 1'h0;
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'h1;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        while (!done) begin
            @(posedge clock);
            if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
            if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid === 1'h1) begin
                r = s_axi_bresp;
                s_axi_bready <= 1'h0;
                done = 1'h1;
            end
        end
    endtask

    task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        logic done;
        done = 1'h0;
        @(posedge clock);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        while (!done) begin
            @(posedge clock);
            if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid === 1'h1) begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'h0;
                done = 1'h1;
            end
        end
    endtask

    // Returns at the edge that samples the n-th update strobe
    task automatic wait_updates(input int n);
        repeat (n) begin
            @(posedge clock);
            while (monitor_output_two_strobe !== 1'h1) @(posedge clock);
        end
    endtask

    task automatic final_report();
        if (failures == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (8) @(posedge clock);
        srst <= 1'h0;
        // Two updates per row: the first may still use the old settings
        // The loop only ever writes the control word; the variable value
        // it plays is set from each row, whatever address is selected
        foreach (rows[i]) begin
            monitored_variable_value <= rows[i].value;
            axi_write(CTRL_BYTE_ADDR, rows[i].ctrl, 4'hF, resp);
            check(32'(resp), 32'(RESP_OKAY), "ctrl write resp");
            check(32'(monitored_variable_address), 32'(rows[i].ctrl[13:0]), "address");
            axi_read(CTRL_BYTE_ADDR, data, resp);
            check(data, {18'h0, rows[i].ctrl[13:0]}, "ctrl readback");
            wait_updates(2);
            check({19'h0, monitor_output_two_clipped, monitor_output_two},
                  {19'h0, rows[i].clip, rows[i].code}, "code");
            axi_read(STATUS_BYTE_ADDR, data, resp);
            check(data, {19'h0, rows[i].clip, rows[i].code}, "status");
        end
        // Single byte lane moves only the low address byte
        axi_write(CTRL_BYTE_ADDR, 32'h000000A5, 4'h1, resp);
        check(32'(monitored_variable_address), 32'h32A5, "byte lane");
        // Refused writes must leave the control word untouched
        axi_write(STATUS_BYTE_ADDR, 32'h0, 4'hF, resp);
        check(32'(resp), 32'(RESP_SLVERR), "status write resp");
        axi_write(12'h000, 32'h0, 4'hF, resp);
        check(32'(resp), 32'(RESP_SLVERR), "unmapped write resp");
        axi_read(12'h000, data, resp);
        check({data[29:0], resp}, 32'(RESP_SLVERR), "unmapped read");
        axi_read(CTRL_BYTE_ADDR, data, resp);
        check(data, 32'h000032A5, "ctrl kept");
        // Mid-run reset brings back unit factor and bipolar range
        monitored_variable_value <= 32'h00004000;
        srst <= 1'h1;
        repeat (8) @(posedge clock);
        srst <= 1'h0;
        @(posedge clock);
        check(32'(monitored_variable_address), 32'h0, "reset address");
        check(32'(monitor_output_two), 32'h0, "reset code");
        axi_read(CTRL_BYTE_ADDR, data, resp);
        check(data, 32'h0, "reset ctrl");
        wait_updates(1);
        check(32'(monitor_output_two), 32'hBFF, "default scaling");
        final_report();
    end

    // Watchdog well beyond the few thousand cycles the tests need
    initial begin
        repeat (20000) @(posedge clock);
        failures++;
        final_report();
    end
endmodule
`default_nettype wire
